// ---- shared/mpp_regs.svh ----
// Summary of operation
// - Port C: four pins, per-pin direction register
// - Port C: per-pin pull-up while input
// - Port C control mode routes timer/interrupt functions
// - External interrupts: rising, falling or both edges
// - Open-drain port: per-pin direction, fixed pull-up
// - Six input-only pins, alternately analog inputs
// - Port G: three pins, one pull-up bit
// - Optional port H: two pins, one pull-up
// - Optional port I: eight pins, one pull-up
`ifndef MPP_REGS_SVH
`define MPP_REGS_SVH

`define MPP_ADDR_W        5
`define MPP_DATA_W        8

`define MPP_OFF_PC_DATA   5'h00
`define MPP_OFF_PC_DIR    5'h01
`define MPP_OFF_PC_PU     5'h02
`define MPP_OFF_PC_ALT    5'h03
`define MPP_OFF_OD_DATA   5'h04
`define MPP_OFF_OD_DIR    5'h05
`define MPP_OFF_IN_DATA   5'h06
`define MPP_OFF_IN_ALT    5'h07
`define MPP_OFF_PG_DATA   5'h08
`define MPP_OFF_PG_DIR    5'h09
`define MPP_OFF_PG_PU     5'h0A
`define MPP_OFF_PH_DATA   5'h0B
`define MPP_OFF_PH_DIR    5'h0C
`define MPP_OFF_PH_PU     5'h0D
`define MPP_OFF_PI_DATA   5'h0E
`define MPP_OFF_PI_DIR    5'h0F
`define MPP_OFF_PI_PU     5'h10
`define MPP_OFF_EDGE_SEL  5'h11
`define MPP_OFF_IRQ_STAT  5'h12
`define MPP_OFF_IRQ_MASK  5'h13

// Field positions
`define MPP_PU_ALL_BIT    0
`define MPP_ALT_CAPT_BIT  0
`define MPP_ALT_TCLK_BIT  1

// Reset values: direction 1 = input, so after reset all pins float except open-drain pins whose OD_PULLUP bit is set
`define MPP_DIR_RST       8'hFF
`define MPP_LATCH_RST     8'h00
`define MPP_PU_RST        8'h00
`define MPP_ALT_RST       8'h00
`define MPP_EDGE_RST      8'h00
`define MPP_MASK_RST      8'h00

`endif

// ---- shared/mpp_pkg.sv ----
`default_nettype none
package mpp_pkg;
  typedef enum logic [1:0] {
    mpp_edge_rise = 2'b00,
    mpp_edge_fall = 2'b01,
    mpp_edge_both = 2'b10,
    mpp_edge_off  = 2'b11
  } mpp_edge_t;
endpackage : mpp_pkg
`default_nettype wire

// ---- hw/mpp_sync.sv ----
`default_nettype none
module mpp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         rst_in,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1_r;
  logic [W-1:0] stage1_nxt;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage2_nxt;

  always_comb begin
    stage1_nxt = async_in;
    stage2_nxt = stage1_r;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign sync_out = stage2_r;
endmodule : mpp_sync
`default_nettype wire

// ---- hw/mpp_edge_det.sv ----
`default_nettype none
module mpp_edge_det
  import mpp_pkg::*;
#(
  parameter int N = 4
) (
  // Clock and reset
  input  wire logic           ref_clk_in,
  input  wire logic           rst_in,
  // Synchronised pins and per-input setup
  input  wire logic [N-1:0]   level_in,
  input  wire logic [N-1:0]   enable_in,
  input  wire logic [2*N-1:0] edge_sel_in,
  // One-cycle event per input
  output logic      [N-1:0]   event_out
);
  logic [N-1:0] prev_r;
  logic [N-1:0] prev_nxt;

  always_comb begin
    prev_nxt = level_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      prev_r <= '0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_edge
      logic      rise;
      logic      fall;
      mpp_edge_t mode;
      assign mode = mpp_edge_t'(edge_sel_in[2*gi +: 2]);
      assign rise = level_in[gi] & ~prev_r[gi];
      assign fall = ~level_in[gi] & prev_r[gi];
      always_comb begin
        case (mode)
          mpp_edge_rise: event_out[gi] = enable_in[gi] & rise;
          mpp_edge_fall: event_out[gi] = enable_in[gi] & fall;
          mpp_edge_both: event_out[gi] = enable_in[gi] & (rise | fall);
          default:       event_out[gi] = 1'b0;
        endcase
      end
    end
  endgenerate
endmodule : mpp_edge_det
`default_nettype wire

// ---- hw/mpp_ports.sv ----
// Design decisions made here: the register addresses and strobed register access.
`include "mpp_regs.svh"
`default_nettype none
module mpp_ports
  import mpp_pkg::*;
#(
  parameter bit         HAS_PORT_H = 1'b1,
  parameter bit         HAS_PORT_I = 1'b1,
  parameter logic [3:0] OD_PULLUP  = 4'h0
) (
  // Clock and reset
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_in,
  // Register port
  input  wire logic [`MPP_ADDR_W-1:0] reg_addr_in,
  input  wire logic [`MPP_DATA_W-1:0] reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [`MPP_DATA_W-1:0] reg_rdata_out,
  output logic                        irq_out,
  // Port C
  input  wire logic [3:0]             port_c_pins_in,
  output logic      [3:0]             port_c_pins_out,
  output logic      [3:0]             port_c_pins_oe_out,
  output logic      [3:0]             port_c_pullup_out,
  // Open-drain port
  input  wire logic [3:0]             open_drain_pins_in,
  output logic      [3:0]             open_drain_pins_out,
  output logic      [3:0]             open_drain_pins_oe_out,
  output logic      [3:0]             open_drain_pullup_out,
  // Input-only port
  input  wire logic [5:0]             input_only_pins_in,
  output logic      [5:0]             analog_inputs_sel_out,
  // Port G
  input  wire logic [2:0]             port_g_pins_in,
  output logic      [2:0]             port_g_pins_out,
  output logic      [2:0]             port_g_pins_oe_out,
  output logic      [2:0]             port_g_pullup_out,
  // Port H
  input  wire logic [1:0]             port_h_pins_in,
  output logic      [1:0]             port_h_pins_out,
  output logic      [1:0]             port_h_pins_oe_out,
  output logic      [1:0]             port_h_pullup_out,
  // Port I
  input  wire logic [7:0]             port_i_pins_in,
  output logic      [7:0]             port_i_pins_out,
  output logic      [7:0]             port_i_pins_oe_out,
  output logic      [7:0]             port_i_pullup_out,
  // Timer and interrupt functions
  input  wire logic                   timer_a_out_in,
  input  wire logic                   timer_b_out0_in,
  input  wire logic                   timer_b_out1_in,
  output logic                        capture_edge_out,
  output logic                        timer_b_ext_clock_out,
  output logic      [3:0]             ext_irq_inputs_req_out
);
  localparam logic [1:0] PH_MASK = HAS_PORT_H ? 2'h3 : 2'h0;
  localparam logic [7:0] PI_MASK = HAS_PORT_I ? 8'hFF : 8'h00;

  // Register state
  logic [3:0] pc_lat_r, pc_lat_nxt, pc_dir_r, pc_dir_nxt;
  logic [3:0] pc_pu_r, pc_pu_nxt, pc_alt_r, pc_alt_nxt;
  logic [3:0] od_lat_r, od_lat_nxt, od_dir_r, od_dir_nxt;
  logic [5:0] in_alt_r, in_alt_nxt;
  logic [2:0] pg_lat_r, pg_lat_nxt, pg_dir_r, pg_dir_nxt;
  logic       pg_pu_r, pg_pu_nxt;
  logic [1:0] ph_lat_r, ph_lat_nxt, ph_dir_r, ph_dir_nxt;
  logic       ph_pu_r, ph_pu_nxt;
  logic [7:0] pi_lat_r, pi_lat_nxt, pi_dir_r, pi_dir_nxt;
  logic       pi_pu_r, pi_pu_nxt;
  logic [7:0] edge_sel_r, edge_sel_nxt;
  logic [3:0] irq_st_r, irq_st_nxt, irq_mask_r, irq_mask_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // Output state
  logic [3:0] pc_out_r, pc_out_nxt, pc_oe_r, pc_oe_nxt, pc_pull_r, pc_pull_nxt;
  logic [3:0] od_oe_r, od_oe_nxt;
  logic [2:0] pg_out_r, pg_oe_r, pg_pull_r, pg_out_nxt, pg_oe_nxt, pg_pull_nxt;
  logic [1:0] ph_out_r, ph_oe_r, ph_pull_r, ph_out_nxt, ph_oe_nxt, ph_pull_nxt;
  logic [7:0] pi_out_r, pi_oe_r, pi_pull_r, pi_out_nxt, pi_oe_nxt, pi_pull_nxt;
  logic       capt_r, capt_nxt, tclk_r, tclk_nxt, irq_r, irq_nxt;
  logic [3:0] ext_req_r, ext_req_nxt;

  // Synchronised pins
  logic [26:0] pins_sync;
  logic [3:0]  pc_s, od_s;
  logic [5:0]  in_s;
  logic [2:0]  pg_s;
  logic [1:0]  ph_s;
  logic [7:0]  pi_s;
  logic [3:0]  ext_evt;
  logic [3:0]  ext_en;
  logic        wr_hit_st;

  mpp_sync #(
    .W (27)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   ({port_i_pins_in, port_h_pins_in, port_g_pins_in,
                  input_only_pins_in, open_drain_pins_in, port_c_pins_in}),
    .sync_out   (pins_sync)
  );

  assign {pi_s, ph_s, pg_s, in_s, od_s, pc_s} = pins_sync;

  // Interrupt inputs only listen in control mode with the pin as input
  assign ext_en = pc_alt_r & pc_dir_r;

  mpp_edge_det #(
    .N (4)
  ) u_edge (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .level_in    (pc_s),
    .enable_in   (ext_en),
    .edge_sel_in (edge_sel_r),
    .event_out   (ext_evt)
  );

  // Register writes, interrupt status and read-back
  always_comb begin
    pc_lat_nxt   = pc_lat_r;
    pc_dir_nxt   = pc_dir_r;
    pc_pu_nxt    = pc_pu_r;
    pc_alt_nxt   = pc_alt_r;
    od_lat_nxt   = od_lat_r;
    od_dir_nxt   = od_dir_r;
    in_alt_nxt   = in_alt_r;
    pg_lat_nxt   = pg_lat_r;
    pg_dir_nxt   = pg_dir_r;
    pg_pu_nxt    = pg_pu_r;
    ph_lat_nxt   = ph_lat_r;
    ph_dir_nxt   = ph_dir_r;
    ph_pu_nxt    = ph_pu_r;
    pi_lat_nxt   = pi_lat_r;
    pi_dir_nxt   = pi_dir_r;
    pi_pu_nxt    = pi_pu_r;
    edge_sel_nxt = edge_sel_r;
    irq_mask_nxt = irq_mask_r;
    wr_hit_st    = 1'b0;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `MPP_OFF_PC_DATA:  pc_lat_nxt = reg_wdata_in[3:0];
        `MPP_OFF_PC_DIR:   pc_dir_nxt = reg_wdata_in[3:0];
        `MPP_OFF_PC_PU:    pc_pu_nxt = reg_wdata_in[3:0];
        `MPP_OFF_PC_ALT:   pc_alt_nxt = reg_wdata_in[3:0];
        `MPP_OFF_OD_DATA:  od_lat_nxt = reg_wdata_in[3:0];
        `MPP_OFF_OD_DIR:   od_dir_nxt = reg_wdata_in[3:0];
        `MPP_OFF_IN_ALT:   in_alt_nxt = reg_wdata_in[5:0];
        `MPP_OFF_PG_DATA:  pg_lat_nxt = reg_wdata_in[2:0];
        `MPP_OFF_PG_DIR:   pg_dir_nxt = reg_wdata_in[2:0];
        `MPP_OFF_PG_PU:    pg_pu_nxt = reg_wdata_in[`MPP_PU_ALL_BIT];
        `MPP_OFF_PH_DATA:  ph_lat_nxt = reg_wdata_in[1:0] & PH_MASK;
        `MPP_OFF_PH_DIR:   ph_dir_nxt = reg_wdata_in[1:0] | ~PH_MASK;
        `MPP_OFF_PH_PU:    ph_pu_nxt = reg_wdata_in[`MPP_PU_ALL_BIT] & HAS_PORT_H;
        `MPP_OFF_PI_DATA:  pi_lat_nxt = reg_wdata_in & PI_MASK;
        `MPP_OFF_PI_DIR:   pi_dir_nxt = reg_wdata_in | ~PI_MASK;
        `MPP_OFF_PI_PU:    pi_pu_nxt = reg_wdata_in[`MPP_PU_ALL_BIT] & HAS_PORT_I;
        `MPP_OFF_EDGE_SEL: edge_sel_nxt = reg_wdata_in;
        `MPP_OFF_IRQ_STAT: wr_hit_st = 1'b1;
        `MPP_OFF_IRQ_MASK: irq_mask_nxt = reg_wdata_in[3:0];
        default:           wr_hit_st = 1'b0;
      endcase
    end
    // Set wins over a write-one clear in the same cycle
    irq_st_nxt = (irq_st_r & ~(wr_hit_st ? reg_wdata_in[3:0] : 4'h0)) | ext_evt;
    irq_nxt    = |(irq_st_nxt & irq_mask_nxt);

    rdata_nxt = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `MPP_OFF_PC_DATA:  rdata_nxt = {4'h0, (pc_s & pc_dir_r) | (pc_lat_r & ~pc_dir_r)};
        `MPP_OFF_PC_DIR:   rdata_nxt = {4'h0, pc_dir_r};
        `MPP_OFF_PC_PU:    rdata_nxt = {4'h0, pc_pu_r};
        `MPP_OFF_PC_ALT:   rdata_nxt = {4'h0, pc_alt_r};
        `MPP_OFF_OD_DATA:  rdata_nxt = {4'h0, (od_s & od_dir_r) | (od_lat_r & ~od_dir_r)};
        `MPP_OFF_OD_DIR:   rdata_nxt = {4'h0, od_dir_r};
        // Pins given to the converter read as zero
        `MPP_OFF_IN_DATA:  rdata_nxt = {2'h0, in_s & ~in_alt_r};
        `MPP_OFF_IN_ALT:   rdata_nxt = {2'h0, in_alt_r};
        `MPP_OFF_PG_DATA:  rdata_nxt = {5'h00, (pg_s & pg_dir_r) | (pg_lat_r & ~pg_dir_r)};
        `MPP_OFF_PG_DIR:   rdata_nxt = {5'h00, pg_dir_r};
        `MPP_OFF_PG_PU:    rdata_nxt = {7'h00, pg_pu_r};
        `MPP_OFF_PH_DATA:  rdata_nxt = {6'h00, PH_MASK & ((ph_s & ph_dir_r) | (ph_lat_r & ~ph_dir_r))};
        `MPP_OFF_PH_DIR:   rdata_nxt = {6'h00, ph_dir_r & PH_MASK};
        `MPP_OFF_PH_PU:    rdata_nxt = {7'h00, ph_pu_r};
        `MPP_OFF_PI_DATA:  rdata_nxt = PI_MASK & ((pi_s & pi_dir_r) | (pi_lat_r & ~pi_dir_r));
        `MPP_OFF_PI_DIR:   rdata_nxt = pi_dir_r & PI_MASK;
        `MPP_OFF_PI_PU:    rdata_nxt = {7'h00, pi_pu_r};
        `MPP_OFF_EDGE_SEL: rdata_nxt = edge_sel_r;
        `MPP_OFF_IRQ_STAT: rdata_nxt = {4'h0, irq_st_r};
        `MPP_OFF_IRQ_MASK: rdata_nxt = {4'h0, irq_mask_r};
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pc_lat_r   <= 4'h0;
      pc_dir_r   <= 4'hF;
      pc_pu_r    <= 4'h0;
      pc_alt_r   <= 4'h0;
      od_lat_r   <= 4'h0;
      od_dir_r   <= 4'hF;
      in_alt_r   <= 6'h00;
      pg_lat_r   <= 3'h0;
      pg_dir_r   <= 3'h7;
      pg_pu_r    <= 1'b0;
      ph_lat_r   <= 2'h0;
      ph_dir_r   <= 2'h3;
      ph_pu_r    <= 1'b0;
      pi_lat_r   <= `MPP_LATCH_RST;
      pi_dir_r   <= `MPP_DIR_RST;
      pi_pu_r    <= 1'b0;
      edge_sel_r <= `MPP_EDGE_RST;
      irq_st_r   <= 4'h0;
      irq_mask_r <= 4'h0;
      irq_r      <= 1'b0;
      rdata_r    <= 8'h00;
    end else begin
      pc_lat_r   <= pc_lat_nxt;
      pc_dir_r   <= pc_dir_nxt;
      pc_pu_r    <= pc_pu_nxt;
      pc_alt_r   <= pc_alt_nxt;
      od_lat_r   <= od_lat_nxt;
      od_dir_r   <= od_dir_nxt;
      in_alt_r   <= in_alt_nxt;
      pg_lat_r   <= pg_lat_nxt;
      pg_dir_r   <= pg_dir_nxt;
      pg_pu_r    <= pg_pu_nxt;
      ph_lat_r   <= ph_lat_nxt;
      ph_dir_r   <= ph_dir_nxt;
      ph_pu_r    <= ph_pu_nxt;
      pi_lat_r   <= pi_lat_nxt;
      pi_dir_r   <= pi_dir_nxt;
      pi_pu_r    <= pi_pu_nxt;
      edge_sel_r <= edge_sel_nxt;
      irq_st_r   <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r      <= irq_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // Pin drive, pull-ups and peripheral hand-off
  always_comb begin
    // Control mode swaps latch for timer outputs on pins 1 to 3; pin 0 keeps its latch
    pc_out_nxt    = pc_lat_r;
    pc_out_nxt[1] = pc_alt_r[1] ? timer_a_out_in  : pc_lat_r[1];
    pc_out_nxt[2] = pc_alt_r[2] ? timer_b_out0_in : pc_lat_r[2];
    pc_out_nxt[3] = pc_alt_r[3] ? timer_b_out1_in : pc_lat_r[3];
    pc_oe_nxt     = ~pc_dir_r;
    // Pull-up only while the pin is not driven by latch or timer
    pc_pull_nxt   = pc_pu_r & pc_dir_r;
    od_oe_nxt     = ~od_dir_r & ~od_lat_r;
    pg_out_nxt    = pg_lat_r;
    pg_oe_nxt     = ~pg_dir_r;
    pg_pull_nxt   = {3{pg_pu_r}} & pg_dir_r;
    ph_out_nxt    = ph_lat_r & PH_MASK;
    ph_oe_nxt     = ~ph_dir_r & PH_MASK;
    ph_pull_nxt   = {2{ph_pu_r}} & ph_dir_r & PH_MASK;
    pi_out_nxt    = pi_lat_r & PI_MASK;
    pi_oe_nxt     = ~pi_dir_r & PI_MASK;
    pi_pull_nxt   = {8{pi_pu_r}} & pi_dir_r & PI_MASK;
    capt_nxt      = pc_s[`MPP_ALT_CAPT_BIT] & ext_en[`MPP_ALT_CAPT_BIT];
    tclk_nxt      = pc_s[`MPP_ALT_TCLK_BIT] & ext_en[`MPP_ALT_TCLK_BIT];
    ext_req_nxt   = ext_evt;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pc_out_r  <= 4'h0;
      pc_oe_r   <= 4'h0;
      pc_pull_r <= 4'h0;
      od_oe_r   <= 4'h0;
      pg_out_r  <= 3'h0;
      pg_oe_r   <= 3'h0;
      pg_pull_r <= 3'h0;
      ph_out_r  <= 2'h0;
      ph_oe_r   <= 2'h0;
      ph_pull_r <= 2'h0;
      pi_out_r  <= 8'h00;
      pi_oe_r   <= 8'h00;
      pi_pull_r <= 8'h00;
      capt_r    <= 1'b0;
      tclk_r    <= 1'b0;
      ext_req_r <= 4'h0;
    end else begin
      pc_out_r  <= pc_out_nxt;
      pc_oe_r   <= pc_oe_nxt;
      pc_pull_r <= pc_pull_nxt;
      od_oe_r   <= od_oe_nxt;
      pg_out_r  <= pg_out_nxt;
      pg_oe_r   <= pg_oe_nxt;
      pg_pull_r <= pg_pull_nxt;
      ph_out_r  <= ph_out_nxt;
      ph_oe_r   <= ph_oe_nxt;
      ph_pull_r <= ph_pull_nxt;
      pi_out_r  <= pi_out_nxt;
      pi_oe_r   <= pi_oe_nxt;
      pi_pull_r <= pi_pull_nxt;
      capt_r    <= capt_nxt;
      tclk_r    <= tclk_nxt;
      ext_req_r <= ext_req_nxt;
    end
  end

  // Open-drain pins only ever pull low; fixed pull-up is a build option
  logic [3:0] od_fixed_pu_r;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      od_fixed_pu_r <= 4'h0;
    end else begin
      od_fixed_pu_r <= OD_PULLUP;
    end
  end

  assign reg_rdata_out          = rdata_r;
  assign irq_out                = irq_r;
  assign port_c_pins_out        = pc_out_r;
  assign port_c_pins_oe_out     = pc_oe_r;
  assign port_c_pullup_out      = pc_pull_r;
  assign open_drain_pins_out    = 4'h0;
  assign open_drain_pins_oe_out = od_oe_r;
  assign open_drain_pullup_out  = od_fixed_pu_r;
  assign analog_inputs_sel_out  = in_alt_r;
  assign port_g_pins_out        = pg_out_r;
  assign port_g_pins_oe_out     = pg_oe_r;
  assign port_g_pullup_out      = pg_pull_r;
  assign port_h_pins_out        = ph_out_r;
  assign port_h_pins_oe_out     = ph_oe_r;
  assign port_h_pullup_out      = ph_pull_r;
  assign port_i_pins_out        = pi_out_r;
  assign port_i_pins_oe_out     = pi_oe_r;
  assign port_i_pullup_out      = pi_pull_r;
  assign capture_edge_out       = capt_r;
  assign timer_b_ext_clock_out  = tclk_r;
  assign ext_irq_inputs_req_out = ext_req_r;
endmodule : mpp_ports
`default_nettype wire

// ---- sim/mpp_pin_model.sv ----
`default_nettype none
module mpp_pin_model #(
  parameter int W          = 4,
  parameter bit OPEN_DRAIN = 1'b0
) (
  // Clock
  input  wire logic         ref_clk_in,
  // Device side
  input  wire logic [W-1:0] drive_in,
  input  wire logic [W-1:0] oe_in,
  input  wire logic [W-1:0] pullup_in,
  // Board side
  input  wire logic [W-1:0] ext_val_in,
  input  wire logic [W-1:0] ext_en_in,
  output logic      [W-1:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_r = 1'b0;
  // Undriven pin without pull-up wanders, so a stale value never passes
  always @(posedge ref_clk_in) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe_in[i]) level_out[i] = OPEN_DRAIN ? 1'b0 : drive_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pullup_in[i]) level_out[i] = 1'b1;
      else level_out[i] = float_r;
    end
  end
endmodule : mpp_pin_model
`default_nettype wire

// ---- sim/mpp_ports_props.sv ----
`include "mpp_regs.svh"
`default_nettype none
module mpp_ports_props #(
  parameter logic [3:0] OD_PULLUP = 4'h0
) (
  // Clock, reset, registers
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       irq_out,
  // Pins
  input wire logic [3:0] port_c_pins_in,
  input wire logic [3:0] port_c_pins_oe_out,
  input wire logic [3:0] port_c_pullup_out,
  input wire logic [3:0] open_drain_pins_out,
  input wire logic [3:0] open_drain_pullup_out,
  input wire logic [5:0] analog_inputs_sel_out,
  input wire logic [2:0] port_g_pins_oe_out,
  input wire logic [2:0] port_g_pullup_out,
  input wire logic [7:0] port_i_pins_oe_out,
  input wire logic [3:0] ext_irq_inputs_req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pin_q_r, chg_r;
  // Window covers sync plus edge detect delay
  always_ff @(posedge ref_clk_in) begin
    pin_q_r <= port_c_pins_in;
    chg_r   <= rst_in ? 4'h0 : {chg_r[2:0], |(port_c_pins_in ^ pin_q_r)};
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_rd_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata outside slot");
  property p_rd_unmapped;
    reg_rd_in && reg_addr_in > `MPP_OFF_IRQ_MASK |=> reg_rdata_out == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
  property p_c_dir;
    reg_wr_in && reg_addr_in == `MPP_OFF_PC_DIR
      |-> ##2 port_c_pins_oe_out == ~4'($past(reg_wdata_in, 2));
  endproperty
  a_c_dir: assert property (p_c_dir) else $error("port c enable");
  property p_i_dir;
    reg_wr_in && reg_addr_in == `MPP_OFF_PI_DIR
      |-> ##2 port_i_pins_oe_out == ~$past(reg_wdata_in, 2);
  endproperty
  a_i_dir: assert property (p_i_dir) else $error("port i enable");
  property p_c_pullup;
    (port_c_pins_oe_out & port_c_pullup_out) == 4'h0;
  endproperty
  a_c_pullup: assert property (p_c_pullup) else $error("pull-up on output");
  property p_g_pullup;
    port_g_pullup_out == 3'h0 || port_g_pullup_out == ~port_g_pins_oe_out;
  endproperty
  a_g_pullup: assert property (p_g_pullup) else $error("port g pull-up");
  property p_od;
    !$past(rst_in) && !$past(rst_in, 2)
      |-> open_drain_pins_out == 4'h0 && open_drain_pullup_out == OD_PULLUP;
  endproperty
  a_od: assert property (p_od) else $error("open-drain drive");
  property p_analog;
    reg_wr_in && reg_addr_in == `MPP_OFF_IN_ALT
      |-> ##2 analog_inputs_sel_out == 6'($past(reg_wdata_in, 2));
  endproperty
  a_analog: assert property (p_analog) else $error("analog select");
  property p_irq_clr;
    (reg_wr_in && reg_addr_in == `MPP_OFF_IRQ_STAT && reg_wdata_in == 8'h0F)
      ##1 (ext_irq_inputs_req_out == 4'h0) |-> !irq_out;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq after clear");
  property p_req_cause;
    ext_irq_inputs_req_out != 4'h0 |-> chg_r != 4'h0;
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("request without edge");
  c_irq: cover property ($rose(irq_out));
  c_req: cover property (ext_irq_inputs_req_out != 4'h0);
  c_rd: cover property ($past(reg_rd_in) && reg_rdata_out != 8'h00);
endmodule : mpp_ports_props
bind mpp_ports mpp_ports_props #(.OD_PULLUP(OD_PULLUP)) u_props (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .port_c_pins_in(port_c_pins_in),
  .port_c_pins_oe_out(port_c_pins_oe_out), .port_c_pullup_out(port_c_pullup_out),
  .open_drain_pins_out(open_drain_pins_out),
  .open_drain_pullup_out(open_drain_pullup_out),
  .analog_inputs_sel_out(analog_inputs_sel_out),
  .port_g_pins_oe_out(port_g_pins_oe_out), .port_g_pullup_out(port_g_pullup_out),
  .port_i_pins_oe_out(port_i_pins_oe_out),
  .ext_irq_inputs_req_out(ext_irq_inputs_req_out));
`default_nettype wire

// ---- sim/test_mcu_port_pins_3_to_9.sv ----
`include "mpp_regs.svh"
`default_nettype none
module test_mcu_port_pins_3_to_9;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD[5] = '{4, 4, 3, 2, 8};
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic [4:0]      a = 5'h00;
  logic [7:0]      wd = 8'h00;
  logic            wr = 1'b0, rd = 1'b0;
  logic [5:0]      in6 = 6'h00;
  logic            ta = 1'b0, tb0 = 1'b0, tb1 = 1'b0;
  logic [7:0]      ev[5] = '{default: 8'h00};
  logic [7:0]      ee[5] = '{default: 8'hFF};
  wire logic [7:0] lv[5], po[5], oe[5], pu[5];
  wire logic [7:0] rdat;
  wire logic [5:0] asel;
  wire logic [3:0] req;
  wire logic       irq, cap, tck;
  logic [31:0]     seed = 32'hC9C16BEA;
  logic [7:0]      dir[5], lat[5], pe[5], st, v, m, p, s, e;
  logic [4:0]      base[5] = '{`MPP_OFF_PC_DATA, `MPP_OFF_OD_DATA, `MPP_OFF_PG_DATA,
                               `MPP_OFF_PH_DATA, `MPP_OFF_PI_DATA};
  int              c, mismatches = 0, checks_done = 0, cyc = 0;

  mpp_ports DUT (
    .ref_clk_in(clk), .rst_in(rst), .reg_addr_in(a), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .irq_out(irq),
    .port_c_pins_in(lv[0][3:0]), .port_c_pins_out(po[0][3:0]),
    .port_c_pins_oe_out(oe[0][3:0]), .port_c_pullup_out(pu[0][3:0]),
    .open_drain_pins_in(lv[1][3:0]), .open_drain_pins_out(po[1][3:0]),
    .open_drain_pins_oe_out(oe[1][3:0]), .open_drain_pullup_out(pu[1][3:0]),
    .input_only_pins_in(in6), .analog_inputs_sel_out(asel),
    .port_g_pins_in(lv[2][2:0]), .port_g_pins_out(po[2][2:0]),
    .port_g_pins_oe_out(oe[2][2:0]), .port_g_pullup_out(pu[2][2:0]),
    .port_h_pins_in(lv[3][1:0]), .port_h_pins_out(po[3][1:0]),
    .port_h_pins_oe_out(oe[3][1:0]), .port_h_pullup_out(pu[3][1:0]),
    .port_i_pins_in(lv[4]), .port_i_pins_out(po[4]),
    .port_i_pins_oe_out(oe[4]), .port_i_pullup_out(pu[4]),
    .timer_a_out_in(ta), .timer_b_out0_in(tb0), .timer_b_out1_in(tb1),
    .capture_edge_out(cap), .timer_b_ext_clock_out(tck), .ext_irq_inputs_req_out(req));

  for (genvar k = 0; k < 5; k++) begin : g_pin
    mpp_pin_model #(.W(WD[k]), .OPEN_DRAIN(k == 1)) u_pin (
      .ref_clk_in(clk), .drive_in(po[k][WD[k]-1:0]), .oe_in(oe[k][WD[k]-1:0]),
      .pullup_in(pu[k][WD[k]-1:0]), .ext_val_in(ev[k][WD[k]-1:0]),
      .ext_en_in(ee[k][WD[k]-1:0]), .level_out(lv[k][WD[k]-1:0]));
  end

  function automatic logic [7:0] rnd();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd

  function automatic logic [7:0] rstv(input logic [4:0] ad);
    case (ad)
      `MPP_OFF_PC_DIR, `MPP_OFF_OD_DIR: return 8'h0F;
      `MPP_OFF_PG_DIR: return 8'h07;
      `MPP_OFF_PH_DIR: return 8'h03;
      `MPP_OFF_PI_DIR: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction : rstv

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [4:0] ad, input logic [7:0] d);
    @(posedge clk);
    a  <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] ad, output logic [7:0] d);
    @(posedge clk);
    a  <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdat;
  endtask : rd_reg

  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  always #20 clk = ~clk;

  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (!(i inside {0, 4, 6, 8, 11, 14})) begin
        rd_reg(5'(i), v);
        chk("reset value", rstv(5'(i)), v);
      end
    end
    for (int r = 0; r < 6; r++) begin
      for (int k = 0; k < 5; k++) begin
        m = 8'((1 << WD[k]) - 1);
        dir[k] = rnd() & m;
        lat[k] = rnd() & m;
        p = rnd() & m;
        wr_reg(base[k] + 5'h01, dir[k]);
        wr_reg(base[k], lat[k]);
        if (k != 1) wr_reg(base[k] + 5'h02, p);
        // Pull-up only acts on input bits; released pins must read high
        pe[k] = k == 0 ? p & dir[k] : (k != 1 && p[0]) ? dir[k] : 8'h00;
        ee[k] <= ~pe[k] | rnd();
        ev[k] <= rnd();
        repeat (4) @(posedge clk);
        e = ((((ee[k] & ev[k]) | ~ee[k]) & dir[k]) | (lat[k] & ~dir[k])) & m;
        rd_reg(base[k], v);
        chk("port read", e, v);
        e = (k == 1 ? ~lat[k] & ~dir[k] : ~dir[k]) & m;
        chk("pin enable", e, oe[k] & m);
        chk("pull-up", pe[k], pu[k] & m);
        e = k == 1 ? 8'h00 : lat[k] & ~dir[k];
        chk("drive", e, po[k] & oe[k] & m);
      end
    end
    for (int r = 0; r < 4; r++) begin
      p = rnd() & 8'h3F;
      wr_reg(`MPP_OFF_IN_ALT, p);
      in6 <= 6'(rnd());
      repeat (4) @(posedge clk);
      rd_reg(`MPP_OFF_IN_DATA, v);
      chk("input read", {2'b00, in6 & ~p[5:0]}, v);
      chk("analog select", p, {2'b00, asel});
    end
    wr_reg(`MPP_OFF_PC_PU, 8'h0F);
    wr_reg(`MPP_OFF_PC_DIR, 8'h00);
    wr_reg(`MPP_OFF_PC_ALT, 8'h0F);
    for (int r = 0; r < 4; r++) begin
      p = rnd();
      {tb1, tb0, ta} <= p[2:0];
      repeat (3) @(posedge clk);
      chk("timer drive", {5'h00, p[2:0]}, {5'h00, po[0][3:1]});
      chk("alt pull-up", 8'h00, {4'h0, pu[0][3:0]});
    end
    // Edges off while pins turn round, so no stray events
    wr_reg(`MPP_OFF_EDGE_SEL, 8'hFF);
    ev[0] <= 8'h00;
    ee[0] <= 8'hFF;
    wr_reg(`MPP_OFF_PC_PU, 8'h00);
    wr_reg(`MPP_OFF_PC_DIR, 8'h0F);
    repeat (6) @(posedge clk);
    wr_reg(`MPP_OFF_IRQ_STAT, 8'h0F);
    st = 8'h00;
    for (int r = 0; r < 12; r++) begin
      s = r == 0 ? 8'hE4 : rnd();
      m = rnd() & 8'h0F;
      wr_reg(`MPP_OFF_EDGE_SEL, s);
      wr_reg(`MPP_OFF_IRQ_MASK, m);
      p = rnd() & 8'h0F;
      for (int i = 0; i < 4; i++) begin
        c = int'((s >> (2 * i)) & 8'h03);
        if (p[i] != ev[0][i] && (c == 2 || c == (p[i] ? 0 : 1))) st[i] = 1'b1;
      end
      ev[0] <= p;
      repeat (6) @(posedge clk);
      rd_reg(`MPP_OFF_IRQ_STAT, v);
      chk("irq status", st, v);
      chk("irq line", {7'h00, |(st & m)}, {7'h00, irq});
      chk("capture", {6'h00, p[1:0]}, {6'h00, tck, cap});
      p = rnd() & 8'h0F;
      wr_reg(`MPP_OFF_IRQ_STAT, p);
      st = st & ~p;
    end
    complete_run();
  end
endmodule : test_mcu_port_pins_3_to_9
`default_nettype wire
